// [psg_cmp.sv]
/*
  psg_cmp: one comparison channel: scaling, eight comparator modes,
  hysteresis, under-mode blocking limit and a 20 ms delta history.
  assumes raw is synchronous to clk and tick marks each program cycle.
*/
`timescale 1ns/1ps
module psg_cmp (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                tick,
  input  wire logic signed [31:0]  raw,
  input  wire logic signed [31:0]  mult,
  input  wire psg_pkg::psg_mode_type mode,
  input  wire logic signed [31:0]  level,
  input  wire logic [31:0]         hyst,
  input  wire logic signed [31:0]  blkLim,
  output logic [31:0]              scaled,
  output logic                     cond
);
  import psg_pkg::*;

  localparam logic signed [95:0] PCT_W = 96'(PCT_SCALE);

  typedef struct packed {
    logic [DELTA_CYCLES-1:0][31:0] hist;
    logic [31:0]                   scaled;
    logic                          cond;
  } psg_cmp_type;

  psg_cmp_type q;
  psg_cmp_type d;
  logic signed [63:0] prod;
  logic signed [31:0] sNow, old, absOld, x;
  logic signed [95:0] lhs, base, thr;
  logic               isUnder, isDelta, isRel, isAbs, hit;

  always_comb begin
    d = q;
    prod = raw * mult;
    sNow = prod[47:16];                                    // see [RULE_02]
    old = $signed(q.hist[DELTA_CYCLES-1]);
    absOld = (old < 0) ? -old : old;
    isUnder = (mode == CMP_UNDER) || (mode == CMP_UNDER_ABS);
    isDelta = mode[2];
    isRel = (mode == CMP_DREL) || (mode == CMP_DREL_ABS);
    isAbs = mode[0];
    x = isDelta ? (sNow - old) : sNow;                     // see [RULE_17]
    if (isAbs && x < 0) begin
      x = -x;                                              // see [RULE_12]
    end
    lhs = isRel ? 96'(x) * PCT_W : 96'(x);                 // see [RULE_15]
    base = isRel ? 96'(level) * 96'(absOld) : 96'(level);
    if (isDelta && !isAbs && level < 0) begin
      lhs = -lhs;
      base = -base;
    end
    lhs = lhs * PCT_W;
    if (!q.cond) begin
      thr = base * PCT_W;                                  // see [RULE_08]
    end else if (isUnder) begin
      thr = base * (PCT_W + $signed({64'h0, hyst}));       // see [RULE_09]
    end else begin
      thr = base * (PCT_W - $signed({64'h0, hyst}));
    end
    if (isUnder) begin
      hit = (lhs < thr) && (sNow >= blkLim);               // see [RULE_13] [RULE_14]
    end else begin
      hit = lhs > thr;                                     // see [RULE_11] [RULE_16] [RULE_18]
    end
    if (tick) begin
      d.scaled = sNow;
      d.cond = hit;
      d.hist = {q.hist[DELTA_CYCLES-2:0], sNow};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign scaled = q.scaled;
  assign cond   = q.cond;

  AST_UNDER_SUPPRESSED: assert property (@(posedge clk) disable iff (rst) // see [RULE_13]
    ce && tick && mode == CMP_UNDER && sNow < blkLim |=> !cond)
    else $error("under comparison active below blocking limit");
  AST_OVER_PICKS: assert property (@(posedge clk) disable iff (rst) // see [RULE_11]
    ce && tick && mode == CMP_OVER && sNow > level |=> cond)
    else $error("over comparison missed pick-up");
endmodule

// [psg_div.sv]
/*
  psg_div: serial restoring divider, 64-bit dividend by 32-bit divisor.
  assumes start is a one-cycle pulse; a new start restarts the division.
*/
`timescale 1ns/1ps
module psg_div (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [63:0] dividend,
  input  wire logic [31:0] divisor,
  output logic             done,
  output logic [63:0]      quotient
);
  import psg_pkg::*;

  typedef struct packed {
    logic [6:0]  cnt;
    logic        busy;
    logic        done;
    logic [32:0] rem;
    logic [63:0] quo;
  } psg_div_type;

  psg_div_type q;
  psg_div_type d;
  logic [32:0] trial;

  always_comb begin
    d = q;
    d.done = 1'b0;
    trial = {q.rem[31:0], q.quo[63]};
    if (start) begin
      d.busy = 1'b1;
      d.cnt = 7'h00;
      d.rem = 33'h0;
      d.quo = dividend;
    end else if (q.busy) begin
      d.quo = {q.quo[62:0], 1'b0};
      if (trial >= {1'b0, divisor}) begin
        d.rem = trial - {1'b0, divisor};
        d.quo[0] = 1'b1;
      end else begin
        d.rem = trial;
      end
      d.cnt = q.cnt + 7'h01;
      if (q.cnt == DIV_STEPS) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign done     = q.done;
  assign quotient = q.quo;
endmodule

// [psg_meas_src.sv]
/*
  psg_meas_src: model of the measurement subsystem and blocking matrix.
  assumes the bench sets target values; outputs move at a clock edge.
*/
`timescale 1ns/1ps
module psg_meas_src (
  input  wire logic        clk,
  input  wire logic [31:0] setA,
  input  wire logic [31:0] setB,
  input  wire logic [31:0] setC,
  input  wire logic        setBlk,
  output logic [31:0]      measA,
  output logic [31:0]      measB,
  output logic [31:0]      measC,
  output logic             blockIn
);
  // values registered; block set whole cycles ahead of trip
  always_ff @(posedge clk) begin
    measA   <= setA;
    measB   <= setB;
    measC   <= setC;
    blockIn <= setBlk;
  end
endmodule

// [psg_pkg.sv]
/*
  psg_pkg: constants, register offsets, reset values and types of the
  programmable threshold stage.
  assumes a 50 MHz clock and APB register access with 32-bit data.
*/
package psg_pkg;
  // clock and program cycle timing
  localparam int CLK_HZ          = 50_000_000;
  localparam int PROG_CYCLE_MS   = 5;
  localparam int PROG_CYCLE_CLKS = CLK_HZ / 1000 * PROG_CYCLE_MS;
  localparam int DELTA_WINDOW_MS = 20;
  localparam int DELTA_CYCLES    = DELTA_WINDOW_MS / PROG_CYCLE_MS;
  localparam int TIME_STEP_MS    = 5;
  localparam int NUM_CH          = 3;
  // fixed point: 1.0 is 10000, 100 % is 1000000
  localparam longint FIX_SCALE   = 64'h0000_0000_0000_2710;
  localparam longint PCT_SCALE   = 64'h0000_0000_000f_4240;
  localparam logic [6:0] DIV_STEPS = 7'h3f;
  // reset values
  localparam logic [31:0] LEVEL_RST  = 32'h0000_0064;
  localparam logic [31:0] HYST_RST   = 32'h0000_7530;
  localparam logic [31:0] MULT_RST   = 32'h0001_0000;
  localparam logic [31:0] BLKLIM_RST = 32'h8000_0000;
  localparam logic [31:0] CALC_RST   = 32'h0000_0064;
  localparam logic [15:0] OPDLY_RST  = 16'h0008;
  localparam logic [15:0] RLDLY_RST  = 16'h000c;
  localparam logic [1:0]  CHCNT_RST  = 2'h1;
  // global register offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_OPDLY      = 8'h04;
  localparam logic [7:0] REG_RLDLY      = 8'h08;
  localparam logic [7:0] REG_CALCLVL    = 8'h0c;
  localparam logic [7:0] REG_COND       = 8'h10;
  localparam logic [7:0] REG_REMAIN     = 8'h14;
  localparam logic [7:0] REG_EXPECT     = 8'h18;
  localparam logic [7:0] REG_RATIO_CALC = 8'h1c;
  // per channel offsets inside a 32-byte window at 0x20, 0x40, 0x60
  localparam logic [4:0] CH_MODE   = 5'h00;
  localparam logic [4:0] CH_MULT   = 5'h04;
  localparam logic [4:0] CH_LEVEL  = 5'h08;
  localparam logic [4:0] CH_HYST   = 5'h0c;
  localparam logic [4:0] CH_BLKLIM = 5'h10;
  localparam logic [4:0] CH_SCALED = 5'h14;
  localparam logic [4:0] CH_RATIO  = 5'h18;

  typedef enum logic [2:0] {
    CMP_OVER      = 3'b000,
    CMP_OVER_ABS  = 3'b001,
    CMP_UNDER     = 3'b010,
    CMP_UNDER_ABS = 3'b011,
    CMP_DREL      = 3'b100,
    CMP_DREL_ABS  = 3'b101,
    CMP_DVAL      = 3'b110,
    CMP_DVAL_ABS  = 3'b111
  } psg_mode_type;

  typedef enum logic [1:0] {
    COND_NORMAL  = 2'b00,
    COND_START   = 2'b01,
    COND_TRIP    = 2'b10,
    COND_BLOCKED = 2'b11
  } psg_cond_type;
endpackage

// [psg_stage.sv]
/*
  psg_stage: programmable protection stage with three comparison channels,
  start, trip and blocked conditions, timers and APB register file.
  assumes measurement values and blocking input are synchronous to clk,
  and the program cycle is long enough for four ratio divisions.
*/
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] one to three channels, own settings each
// [RULE_02] scaled value is raw times multiplier
// [RULE_03] condition is normal, start, trip or blocked
// [RULE_04] ratio measured to level per channel readable
// [RULE_05] ratio calculated magnitude to level readable
// [RULE_06] remaining time counts down toward trip
// [RULE_07] expected operating time is readable
// [RULE_08] level is the allowed boundary
// [RULE_09] release hysteresis percent of level, default 3
// [RULE_10] eight modes, greater-than after reset
// [RULE_11] greater-than compares signed scaled value
// [RULE_12] absolute greater-than compares magnitude
// [RULE_13] less-than, suppressed below blocking limit
// [RULE_14] absolute less-than, suppressed below limit
// [RULE_15] signed relative change over 20 ms
// [RULE_16] absolute relative change over 20 ms
// [RULE_17] signed value change over 20 ms
// [RULE_18] absolute value change over 20 ms
// [RULE_19] signed level, 0.0001 step, default 0.01
// [RULE_20] trip after operate delay, default 0.04 s
// [RULE_21] release delay before start clears
// [RULE_22] blocking sampled each cycle decides start/blocked
// [RULE_23] blocking during start clears start, releases
// [RULE_24] blocking source must lead trip by 5 ms
// [RULE_25] pick-up combines channels once per cycle
// [RULE_26] remaining time reaches zero at trip
module psg_stage #(
  parameter int PROG_CYCLE_CLKS = psg_pkg::PROG_CYCLE_CLKS
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [31:0]          measA,
  input  wire logic [31:0]          measB,
  input  wire logic [31:0]          measC,
  input  wire logic                 blockIn,
  output logic                      startOut,
  output logic                      tripOut,
  output logic                      blockedOut,
  output psg_pkg::psg_cond_type     condOut
);
  import psg_pkg::*;

  localparam int CYC_W = $clog2(PROG_CYCLE_CLKS);

  typedef struct packed {
    logic [CYC_W-1:0]               cycCnt;
    logic                           tick;
    logic                           tickLate;
    logic [1:0]                     chCnt;
    logic [15:0]                    opDly;
    logic [15:0]                    rlDly;
    logic [31:0]                    calcLvl;
    psg_mode_type [NUM_CH-1:0]      mode;
    logic [NUM_CH-1:0][31:0]        mult;
    logic [NUM_CH-1:0][31:0]        level;
    logic [NUM_CH-1:0][31:0]        hyst;
    logic [NUM_CH-1:0][31:0]        blkLim;
    psg_cond_type                   cond;
    logic [15:0]                    opCnt;
    logic [15:0]                    relCnt;
    logic                           releasing;
    logic [NUM_CH:0][31:0]          ratio;
    logic [1:0]                     ratIdx;
    logic                           ratBusy;
    logic                           divStart;
    logic                           pready;
    logic                           pslverr;
    logic [31:0]                    prdata;
    logic                           startOut;
    logic                           tripOut;
    logic                           blockedOut;
    logic [31:0]                    remainMs;
    logic [31:0]                    expectMs;
  } psg_state_type;

  psg_state_type q;
  psg_state_type d;

  logic [NUM_CH-1:0][31:0] measV;
  logic [NUM_CH-1:0][31:0] scaledV;
  logic [NUM_CH-1:0]       condV;
  logic                    pick;
  logic                    drop;
  logic [31:0]             calcMag;
  logic signed [31:0]      num;
  logic signed [31:0]      den;
  logic [63:0]             divDividend;
  logic [31:0]             divDivisor;
  logic                    divDone;
  logic [63:0]             divQuo;
  logic [31:0]             ratioMag;

  function automatic logic [1:0] chIndex(input logic [7:0] a);
    chIndex = a[7] ? 2'h0 : a[6:5];
  endfunction

  assign measV = {measC, measB, measA};

  // comparison channels
  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      psg_cmp u_cmp (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .tick   (q.tick),
        .raw    (measV[i]),
        .mult   (q.mult[i]),
        .mode   (q.mode[i]),
        .level  (q.level[i]),
        .hyst   (q.hyst[i]),
        .blkLim (q.blkLim[i]),
        .scaled (scaledV[i]),
        .cond   (condV[i])
      );
    end
  endgenerate

  // pick-up and calculated magnitude over the active channels
  always_comb begin
    pick = 1'b1;
    calcMag = 32'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (i < int'(q.chCnt)) begin
        pick = pick & condV[i];                            // see [RULE_25] [RULE_01]
        calcMag = calcMag + scaledV[i];
      end
    end
  end

  // ratio operands, one division at a time
  always_comb begin
    num = (q.ratIdx == 2'h3) ? $signed(calcMag) : $signed(scaledV[q.ratIdx]);
    den = (q.ratIdx == 2'h3) ? $signed(q.calcLvl) : $signed(q.level[q.ratIdx]);
    divDividend = 64'(num < 0 ? -num : num) * FIX_SCALE;
    divDivisor = (den < 0) ? 32'(-den) : 32'(den);
    ratioMag = (divQuo[63:31] != 33'h0) ? 32'h7fff_ffff : divQuo[31:0];
  end

  psg_div u_div (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .start    (q.divStart),
    .dividend (divDividend),
    .divisor  (divDivisor),
    .done     (divDone),
    .quotient (divQuo)
  );

  always_comb begin
    logic [31:0] rd;
    logic        hit;
    logic [1:0]  chSel;
    rd = 32'h0;
    hit = 1'b1;
    chSel = chIndex(paddr);
    d = q;
    d.divStart = 1'b0;
    d.pready = 1'b0;
    d.tickLate = q.tick;
    // program cycle timebase
    if (q.cycCnt == CYC_W'(PROG_CYCLE_CLKS - 1)) begin
      d.cycCnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cycCnt = q.cycCnt + CYC_W'(1);
      d.tick = 1'b0;
    end
    // read decode
    if (chSel != 2'h0) begin
      case (paddr[4:0])
        CH_MODE:   rd = {29'h0, q.mode[chSel - 2'h1]};
        CH_MULT:   rd = q.mult[chSel - 2'h1];
        CH_LEVEL:  rd = q.level[chSel - 2'h1];
        CH_HYST:   rd = q.hyst[chSel - 2'h1];
        CH_BLKLIM: rd = q.blkLim[chSel - 2'h1];
        CH_SCALED: rd = scaledV[chSel - 2'h1];
        CH_RATIO:  rd = q.ratio[chSel - 2'h1];             // see [RULE_04]
        default:   hit = 1'b0;
      endcase
    end else begin
      case (paddr)
        REG_CTRL:       rd = {30'h0, q.chCnt};
        REG_OPDLY:      rd = {16'h0, q.opDly};
        REG_RLDLY:      rd = {16'h0, q.rlDly};
        REG_CALCLVL:    rd = q.calcLvl;
        REG_COND:       rd = {30'h0, q.cond};
        REG_REMAIN:     rd = q.remainMs;
        REG_EXPECT:     rd = q.expectMs;
        REG_RATIO_CALC: rd = q.ratio[NUM_CH];               // see [RULE_05]
        default:        hit = 1'b0;
      endcase
    end
    if (psel && !penable) begin
      d.pready = 1'b1;
      d.prdata = rd;
      d.pslverr = !hit;
    end
    // register writes at the completing access edge
    if (psel && penable && q.pready && pwrite) begin
      if (chSel != 2'h0) begin
        case (paddr[4:0])
          CH_MODE:   d.mode[chSel - 2'h1] = psg_mode_type'(pwdata[2:0]); // see [RULE_10]
          CH_MULT:   d.mult[chSel - 2'h1] = pwdata;
          CH_LEVEL:  d.level[chSel - 2'h1] = pwdata;       // see [RULE_19]
          CH_HYST:   d.hyst[chSel - 2'h1] = pwdata;
          CH_BLKLIM: d.blkLim[chSel - 2'h1] = pwdata;
          default:   d.prdata = q.prdata;
        endcase
      end else begin
        case (paddr)
          REG_CTRL:    d.chCnt = (pwdata[1:0] == 2'h0) ? 2'h1 : pwdata[1:0];
          REG_OPDLY:   d.opDly = pwdata[15:0];
          REG_RLDLY:   d.rlDly = pwdata[15:0];             // see [RULE_21]
          REG_CALCLVL: d.calcLvl = pwdata;
          default:     d.prdata = q.prdata;
        endcase
      end
    end
    // ratio sequencer, restarted each program cycle
    if (q.tickLate) begin
      d.ratIdx = 2'h0;
      d.ratBusy = 1'b1;
      d.divStart = 1'b1;
    end else if (q.ratBusy && divDone) begin
      d.ratio[q.ratIdx] = ((num < 0) != (den < 0)) ? -ratioMag : ratioMag;
      if (q.ratIdx == 2'h3) begin
        d.ratBusy = 1'b0;
      end else begin
        d.ratIdx = q.ratIdx + 2'h1;
        d.divStart = 1'b1;
      end
    end
    // condition sequencing, once per program cycle
    case (q.cond)
      COND_START:   drop = !pick || blockIn;
      COND_TRIP:    drop = !pick;
      COND_BLOCKED: drop = !pick || !blockIn || q.releasing;
      default:      drop = 1'b0;
    endcase
    if (q.tickLate) begin
      if (q.cond == COND_NORMAL) begin
        if (pick && blockIn) begin
          d.cond = COND_BLOCKED;                           // see [RULE_22]
        end else if (pick && q.opDly == 16'h0) begin
          d.cond = COND_TRIP;
          d.opCnt = 16'h0;
        end else if (pick) begin
          d.cond = COND_START;
          d.opCnt = q.opDly;                               // see [RULE_20]
        end
      end else if (drop) begin
        if (q.cond == COND_START && blockIn) begin
          d.cond = COND_BLOCKED;                           // see [RULE_23]
        end
        if (q.releasing ? (q.relCnt <= 16'h1) : (q.rlDly <= 16'h1)) begin
          d.cond = COND_NORMAL;
          d.releasing = 1'b0;
          d.relCnt = 16'h0;
          d.opCnt = 16'h0;
        end else begin
          d.releasing = 1'b1;                              // see [RULE_21]
          d.relCnt = q.releasing ? q.relCnt - 16'h1 : q.rlDly - 16'h1;
        end
      end else begin
        d.releasing = 1'b0;
        if (q.cond == COND_START && q.opCnt <= 16'h1) begin
          d.cond = COND_TRIP;
          d.opCnt = 16'h0;                                 // see [RULE_26]
        end else if (q.cond == COND_START) begin
          d.opCnt = q.opCnt - 16'h1;                       // see [RULE_06]
        end
      end
    end
    d.startOut = d.cond == COND_START;                     // see [RULE_03]
    d.tripOut = d.cond == COND_TRIP;
    d.blockedOut = d.cond == COND_BLOCKED;
    d.remainMs = (d.cond == COND_START) ? 32'(d.opCnt) * 32'(TIME_STEP_MS) : 32'h0;
    d.expectMs = 32'(d.opDly) * 32'(TIME_STEP_MS);         // see [RULE_07]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.chCnt <= CHCNT_RST;
      q.opDly <= OPDLY_RST;
      q.rlDly <= RLDLY_RST;
      q.calcLvl <= CALC_RST;
      q.mode <= {NUM_CH{CMP_OVER}};
      q.mult <= {NUM_CH{MULT_RST}};
      q.level <= {NUM_CH{LEVEL_RST}};
      q.hyst <= {NUM_CH{HYST_RST}};
      q.blkLim <= {NUM_CH{BLKLIM_RST}};
      q.cond <= COND_NORMAL;
      q.expectMs <= 32'(OPDLY_RST) * 32'(TIME_STEP_MS);
    end else if (ce) begin
      q <= d;
    end
  end

  assign prdata     = q.prdata;
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign startOut   = q.startOut;
  assign tripOut    = q.tripOut;
  assign blockedOut = q.blockedOut;
  assign condOut    = q.cond;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence sEval;
    ce && q.tickLate;
  endsequence
  sequence sFreshPick;
    sEval ##0 (q.cond == COND_NORMAL) && pick;
  endsequence
  sequence sCounting;
    sEval ##0 startOut && pick && !blockIn;
  endsequence

  AST_ONE_CONDITION: assert property ($onehot0({startOut, tripOut, blockedOut})) // see [RULE_03]
    else $error("more than one condition output active");
  AST_BLOCKED_ON_PICKUP: assert property (sFreshPick ##0 blockIn |=> blockedOut && !startOut) // see [RULE_22]
    else $error("blocked pick-up did not give blocked");
  AST_START_SHOWS_EXPECTED: assert property (sFreshPick ##0 !blockIn && q.opDly > 16'h1 // see [RULE_07]
    |=> startOut && q.remainMs == q.expectMs)
    else $error("start entry remaining time differs from expected time");
  AST_REMAIN_COUNTS_DOWN: assert property (sCounting ##0 q.opCnt > 16'h1 // see [RULE_06]
    |=> startOut && q.remainMs == $past(q.remainMs) - 32'(TIME_STEP_MS))
    else $error("remaining time did not drop by one step");
  AST_TRIP_ON_EXPIRY: assert property (sCounting ##0 q.opCnt == 16'h1 |=> tripOut) // see [RULE_20]
    else $error("trip missing at end of operate delay");
  AST_TRIP_AT_ZERO: assert property ($rose(tripOut) |-> q.remainMs == 32'h0) // see [RULE_26]
    else $error("remaining time not zero at trip");
  AST_BLOCK_DROPS_START: assert property (sEval ##0 startOut && blockIn // see [RULE_23]
    |=> !startOut && (blockedOut || condOut == COND_NORMAL))
    else $error("start not cleared by blocking");
  AST_RELEASE_HOLDS: assert property (sEval ##0 startOut && !pick && !blockIn // see [RULE_21]
    && q.releasing && q.relCnt > 16'h1 |=> startOut)
    else $error("start cleared before release delay");
  AST_HELD_BETWEEN_CYCLES: assert property (ce && !q.tickLate |=> $stable(condOut)) // see [RULE_25]
    else $error("condition changed outside program cycle");
endmodule

// [testbench.sv]
/*
  testbench: drives the stage over APB and through the source model.
  assumes a shortened program cycle of 400 clocks.
*/
`timescale 1ns/1ps
module testbench;
  import psg_pkg::*;
  localparam int PC = 400;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   paddr = 8'h00;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  setA = 32'h0;
  logic         blk = 1'b0;
  logic [31:0]  prdata, measA, measB, measC, v;
  logic         pready, pslverr, blockIn, startOut, tripOut, blockedOut;
  psg_cond_type condOut;
  logic [32:0]  expQ[$];
  int           miscompares = 0;
  int           samples_checked = 0;
  int           n;
  always #10 clk = ~clk;
  psg_meas_src u_psg_meas_src (.clk(clk), .setA(setA), .setB(32'h0), .setC(32'h0),
    .setBlk(blk), .measA(measA), .measB(measB), .measC(measC), .blockIn(blockIn));
  psg_stage #(.PROG_CYCLE_CLKS(PC)) u_psg_stage (.clk(clk), .rst(rst), .ce(1'b1),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .measA(measA), .measB(measB),
    .measC(measC), .blockIn(blockIn), .startOut(startOut), .tripOut(tripOut),
    .blockedOut(blockedOut), .condOut(condOut));
  task automatic give_verdict();
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    tmo(k, 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
    expQ.push_back({e, d});
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic waitPc(input int c);
    repeat (c * PC) @(posedge clk);
  endtask
  // read results compared in arrival order
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, expQ.pop_front());
  end
  initial begin
    logic [20:0] md;
    logic [6:0]  ng, bg, ex;
    md = {3'd3, 3'd3, 3'd2, 3'd2, 3'd1, 3'd0, 3'd0};
    ng = 7'b0110110;
    bg = 7'b0000111;
    ex = 7'b1001101;
    void'($urandom(32'h14a9));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(REG_CTRL, 32'h1, 1'b0);
    rd(REG_OPDLY, 32'h8, 1'b0);
    rd(REG_RLDLY, 32'hc, 1'b0);
    rd(REG_EXPECT, 32'h28, 1'b0);
    rd({3'h1, CH_MODE}, 32'h0, 1'b0);
    rd({3'h1, CH_LEVEL}, 32'h64, 1'b0);
    rd({3'h1, CH_HYST}, 32'h7530, 1'b0);
    rd(REG_COND, 32'h0, 1'b0);
    rd(8'hf0, 32'h0, 1'b1);
    xfer(REG_RLDLY, 1'b1, 32'h1);
    xfer(REG_OPDLY, 1'b1, 32'h64);
    xfer({3'h1, CH_BLKLIM}, 1'b1, 32'h0);
    for (int i = 0; i < 7; i++) begin
      v = bg[i] ? 32'd200 + $urandom % 800 : 32'd10 + $urandom % 80;
      xfer({3'h1, CH_MODE}, 1'b1, {29'h0, md[i*3+:3]});
      setA <= ng[i] ? -v : v;
      waitPc(3);
      rd(REG_COND, {31'h0, ex[i]}, 1'b0);
    end
    setA <= 32'h0;
    xfer(REG_OPDLY, 1'b1, 32'h2);
    xfer({3'h1, CH_MULT}, 1'b1, 32'h0002_0000);
    xfer({3'h1, CH_MODE}, 1'b1, 32'h0);
    waitPc(3);
    setA <= 32'd300;
    n = 0;
    while (startOut !== 1'b1 && n < 4 * PC) begin
      @(posedge clk);
      n++;
    end
    tmo(n, 4 * PC);
    rd(REG_REMAIN, 32'd10, 1'b0);
    // three edges already spent in the read
    n = 3;
    while (tripOut !== 1'b1 && n < 4 * PC) begin
      @(posedge clk);
      n++;
    end
    tmo(n, 4 * PC);
    chk(33'(n), 33'(2 * PC));
    rd(REG_REMAIN, 32'h0, 1'b0);
    rd({3'h1, CH_SCALED}, 32'd600, 1'b0);
    rd({3'h1, CH_RATIO}, 32'd60000, 1'b0);
    rd(REG_RATIO_CALC, 32'd60000, 1'b0);
    setA <= 32'h0;
    waitPc(3);
    blk <= 1'b1;
    setA <= 32'd300;
    waitPc(3);
    chk({31'h0, condOut}, {31'h0, COND_BLOCKED});
    chk({32'h0, blockedOut}, 33'h1);
    blk <= 1'b0;
    setA <= 32'h0;
    xfer(REG_OPDLY, 1'b1, 32'h64);
    waitPc(3);
    setA <= 32'd300;
    waitPc(3);
    chk({32'h0, startOut}, 33'h1);
    blk <= 1'b1;
    waitPc(3);
    chk({32'h0, startOut}, 33'h0);
    rd(REG_COND, {30'h0, COND_BLOCKED}, 1'b0);
    // value step seen over the 20 ms window only
    blk <= 1'b0;
    setA <= 32'h0;
    xfer({3'h1, CH_MODE}, 1'b1, {29'h0, CMP_DVAL});
    waitPc(5);
    setA <= 32'd300;
    waitPc(2);
    rd(REG_COND, {30'h0, COND_START}, 1'b0);
    waitPc(4);
    rd(REG_COND, {30'h0, COND_NORMAL}, 1'b0);
    give_verdict();
  end
endmodule
